// ===== drt_pkg.sv
// Constants and types for the 16K x 1 DRAM host controller
//------------------------------------------------------------
//------------------------------------------------------------
package drt_pkg;

  //----------------------------------------------------------
  // Widths and clock
  //----------------------------------------------------------
  localparam int CLK_NS   = 100;  // Core clock period
  localparam int ROW_W    = 7;    // Row or column word
  localparam int ADDR_W   = 14;   // Cell address
  localparam int SYNC_CYC = 2;    // Data pin synchroniser
  localparam int ROWS_ROR = 128;  // Rows for RAS-only refresh
  localparam int ROWS_CBR = 64;   // Cycles for CBR refresh
  localparam int REF_US   = 2000; // Refresh interval

  //----------------------------------------------------------
  // Edge limits in ns, slowest grade
  //----------------------------------------------------------
  localparam int T_RCL_NS = 60;   // Row to col lead, min
  localparam int T_RAC_NS = 300;  // Row access time
  localparam int T_CAC_NS = 190;  // Col access time
  localparam int T_LIM_NS = 2000; // Lead hard limit
  localparam int T_RAS_NS = 330;  // RAS width
  localparam int T_CAS_NS = 190;  // CAS width
  localparam int T_RSH_NS = 220;  // RAS hold after CAS
  localparam int T_CSH_NS = 300;  // CAS hold after RAS
  localparam int T_RP_NS  = 95;   // RAS precharge
  localparam int T_RWH_NS = 390;  // RMW row hold
  localparam int T_CWH_NS = 460;  // RMW col hold
  localparam int T_RRW_NS = 500;  // RMW RAS width
  localparam int T_CRW_NS = 350;  // RMW CAS width
  localparam int T_CWL_NS = 160;  // Write to CAS lead
  localparam int T_RWL_NS = 200;  // Write to RAS lead
  localparam int T_WP_NS  = 100;  // Write pulse

  // Least time in whole cycles
  function automatic int cyc_up(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction : cyc_up

  // Larger of two
  function automatic int mx(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : mx

  //----------------------------------------------------------
  // Cycle counts, phase 0 is the RAS falling edge
  //----------------------------------------------------------
  localparam int RCL_CYC     = cyc_up(T_RCL_NS);
  localparam int RCL_MAX_CYC = mx(1, (T_RAC_NS - T_CAC_NS) / CLK_NS);
  localparam int RCL_LIM_CYC = T_LIM_NS / CLK_NS;
  localparam int RAC_CYC     = cyc_up(T_RAC_NS);
  // Pin data stands at the access edge; second flop holds it one phase later
  localparam int SAMPLE_CYC  = RAC_CYC + SYNC_CYC - 1;
  localparam int RP_CYC      = cyc_up(T_RP_NS);
  localparam int NRM_CAS_UP  = mx(cyc_up(T_CSH_NS), RCL_CYC + cyc_up(T_CAS_NS));
  localparam int NRM_RAS_UP  = mx(cyc_up(T_RAS_NS), RCL_CYC + cyc_up(T_RSH_NS));
  localparam int REF_RAS_UP  = cyc_up(T_RAS_NS);
  localparam int RMW_WE_DN   = RAC_CYC + 1;
  localparam int RMW_CAS_UP  = mx(mx(cyc_up(T_CWH_NS), RCL_CYC + cyc_up(T_CRW_NS)),
                                  RMW_WE_DN + mx(cyc_up(T_CWL_NS), cyc_up(T_WP_NS)));
  localparam int RMW_RAS_UP  = mx(mx(cyc_up(T_RRW_NS), RCL_CYC + cyc_up(T_RWH_NS)),
                                  mx(RMW_WE_DN + cyc_up(T_RWL_NS), RMW_CAS_UP));
  localparam int RMW_END     = RMW_RAS_UP + RP_CYC;
  localparam int REF_CYC     = REF_US * 1000 / CLK_NS;

  //----------------------------------------------------------
  // Types
  //----------------------------------------------------------
  typedef logic [3:0] drt_ph_t; // Phase counter

  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_RMW   = 2'h2
  } drt_op_t;

  typedef enum logic [2:0] {
    K_RD  = 3'h0,
    K_WR  = 3'h1,
    K_RMW = 3'h2,
    K_ROR = 3'h3,
    K_CBR = 3'h4
  } drt_kind_t;

  typedef struct packed {
    drt_op_t             op;
    logic [ADDR_W-1:0]   addr;
    logic                wdata;
  } drt_req_t;

  typedef struct packed {
    logic                ras_n;
    logic                cas_n;
    logic                we_n;
    logic [ROW_W-1:0]    mux_addr;
    logic                din;
  } drt_pins_t;

  localparam drt_pins_t PINS_IDLE = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                      mux_addr: 7'h00, din: 1'b0};

endpackage : drt_pkg

// ===== drt_host.sv
// Host controller driving a 16K x 1 multiplexed-address DRAM
`timescale 1ns/1ps

module drt_host #(
  parameter int REF_CYC = drt_pkg::REF_CYC // Refresh interval, cycles
) (
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               sys_rst_i,
  // User request
  input  wire logic               req_valid_i,
  input  wire drt_pkg::drt_req_t  req_i,
  output logic                    req_ready_o,
  // User answer
  output logic                    rsp_valid_o,
  output logic                    rsp_rdata_o,
  // Refresh control
  input  wire logic               ref_ras_only_i,
  input  wire logic               hidden_ref_i,
  // DRAM pins
  output drt_pkg::drt_pins_t      pins_o,
  input  wire logic               dout_i
);

  //----------------------------------------------------------
  // Elaboration checks
  //----------------------------------------------------------
  if (REF_CYC / drt_pkg::ROWS_ROR <= 2 * drt_pkg::RMW_END ||
      drt_pkg::RCL_CYC > drt_pkg::RCL_MAX_CYC ||
      drt_pkg::RCL_CYC > drt_pkg::RCL_LIM_CYC ||
      drt_pkg::RMW_END > 15) begin : g_bad_cfg
    $error("drt_host: timing parameters cannot be served");
  end

  localparam int TW = $clog2(REF_CYC); // Timer width

  //----------------------------------------------------------
  // Sequencer states
  //----------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ROW  = 3'b010,
    ST_ACT  = 3'b100
  } drt_st_t;

  // Sequencer state
  drt_st_t              st_reg, st_next;       // Cycle state
  drt_pkg::drt_kind_t   kind_reg, kind_next;   // Cycle kind
  drt_pkg::drt_ph_t     ph_reg, ph_next;       // Phase since RAS
  logic [6:0]           col_reg, col_next;     // Held column
  drt_pkg::drt_pins_t   pin_reg, pin_next;     // Pin drivers
  logic                 ready_reg, ready_next;  // Request ready
  logic                 rsp_v_reg, rsp_v_next; // Answer strobe
  logic                 rdat_reg, rdat_next;   // Read data
  // Refresh state
  logic [TW-1:0]        tmr_reg, tmr_next;     // Interval timer
  logic [1:0]           pend_reg, pend_next;   // Owed refreshes
  logic                 hid_reg, hid_next;     // Hidden refresh due
  logic [6:0]           row_reg, row_next;     // Refresh row
  // Data pin synchroniser
  logic                 dq_s1_reg;             // First stage
  logic                 dq_s2_reg;             // Second stage
  // Decoded helpers
  logic                 data_op;               // Access cycle
  int                   ivl;                   // Cycles per refresh

  //----------------------------------------------------------
  // Cycle kind decoding
  //----------------------------------------------------------

  // Phase at which RAS rises
  function automatic drt_pkg::drt_ph_t ras_up_f(input drt_pkg::drt_kind_t k);
    if (k == drt_pkg::K_RMW) begin
      return drt_pkg::drt_ph_t'(drt_pkg::RMW_RAS_UP);
    end else if (k == drt_pkg::K_ROR || k == drt_pkg::K_CBR) begin
      return drt_pkg::drt_ph_t'(drt_pkg::REF_RAS_UP);
    end
    return drt_pkg::drt_ph_t'(drt_pkg::NRM_RAS_UP);
  endfunction : ras_up_f

  // Phase at which CAS rises
  function automatic drt_pkg::drt_ph_t cas_up_f(input drt_pkg::drt_kind_t k);
    if (k == drt_pkg::K_RMW) begin
      return drt_pkg::drt_ph_t'(drt_pkg::RMW_CAS_UP);
    end else if (k == drt_pkg::K_ROR || k == drt_pkg::K_CBR) begin
      return ras_up_f(k);
    end
    return drt_pkg::drt_ph_t'(drt_pkg::NRM_CAS_UP);
  endfunction : cas_up_f

  assign data_op = (kind_reg == drt_pkg::K_RD) || (kind_reg == drt_pkg::K_WR) ||
                   (kind_reg == drt_pkg::K_RMW);

  // Spacing between refreshes for the mode
  assign ivl = ref_ras_only_i ? REF_CYC / drt_pkg::ROWS_ROR : REF_CYC / drt_pkg::ROWS_CBR;

  //----------------------------------------------------------
  // Next-state logic
  //----------------------------------------------------------
  always_comb begin
    st_next    = st_reg;
    kind_next  = kind_reg;
    ph_next    = ph_reg;
    col_next   = col_reg;
    pin_next   = pin_reg;
    rsp_v_next = 1'b0;
    rdat_next  = rdat_reg;
    row_next   = row_reg;
    hid_next   = hid_reg;
    pend_next  = pend_reg;
    tmr_next   = tmr_reg + 1'b1;
    // Interval tick, counted even when a refresh or access starts in the same cycle
    if (int'(tmr_reg) >= ivl - 1) begin
      tmr_next = '0;
      if (pend_reg != 2'h3) begin
        pend_next = pend_reg + 2'h1;
      end
    end
    case (st_reg)
      ST_IDLE: begin
        // Owed refresh goes before any access
        if (pend_reg != 2'h0 || hid_reg) begin
          // Hidden refresh is RAS-only so read data stays latched
          if (hid_reg || ref_ras_only_i) begin
            kind_next = drt_pkg::K_ROR;
          end else begin
            kind_next = drt_pkg::K_CBR;
          end
          pin_next.we_n     = 1'b1;
          pin_next.mux_addr = row_reg;
          // CBR lowers CAS one cycle before RAS
          pin_next.cas_n    = hid_reg || ref_ras_only_i;
          row_next          = row_reg + 7'h01;
          if (hid_reg) begin
            hid_next = 1'b0;
            tmr_next = '0;
          end else begin
            pend_next = pend_next - 2'h1;
          end
          st_next = ST_ROW;
        end else if (req_valid_i && ready_reg) begin
          // Row word first, column word held for CAS
          pin_next.mux_addr = req_i.addr[6:0];
          col_next          = req_i.addr[13:7];
          // Data stands all cycle, so the later strobe edge captures it
          pin_next.din      = req_i.wdata;
          // Early write lowers WE before CAS; reads keep it high
          pin_next.we_n     = (req_i.op != drt_pkg::OP_WRITE);
          if (req_i.op == drt_pkg::OP_WRITE) begin
            kind_next = drt_pkg::K_WR;
          end else if (req_i.op == drt_pkg::OP_RMW) begin
            kind_next = drt_pkg::K_RMW;
          end else begin
            kind_next = drt_pkg::K_RD;
          end
          st_next = ST_ROW;
        end
      end
      ST_ROW: begin
        // Row strobe falls, phase 0
        pin_next.ras_n = 1'b0;
        ph_next        = '0;
        st_next        = ST_ACT;
      end
      ST_ACT: begin
        ph_next = ph_reg + 1'b1;
        // Column strobe after the lead, well under the limit
        if (data_op && ph_next == drt_pkg::drt_ph_t'(drt_pkg::RCL_CYC)) begin
          pin_next.cas_n    = 1'b0;
          pin_next.mux_addr = col_reg;
        end
        // Modify: write pulse after the read data was sampled
        if (kind_reg == drt_pkg::K_RMW &&
            ph_next == drt_pkg::drt_ph_t'(drt_pkg::RMW_WE_DN)) begin
          pin_next.we_n = 1'b0;
        end
        // CAS and WE rise together
        if (ph_next == cas_up_f(kind_reg)) begin
          pin_next.cas_n = 1'b1;
          pin_next.we_n  = 1'b1;
        end
        if (ph_next == ras_up_f(kind_reg)) begin
          pin_next.ras_n = 1'b1;
        end
        // Latched output sampled after access time
        // Only reads load data; a CAS-first refresh floats the line
        if (ph_reg == drt_pkg::drt_ph_t'(drt_pkg::SAMPLE_CYC) &&
            (kind_reg == drt_pkg::K_RD || kind_reg == drt_pkg::K_RMW)) begin
          rdat_next = dq_s2_reg;
        end
        // End of cycle after precharge
        if (ph_next == ras_up_f(kind_reg) + drt_pkg::drt_ph_t'(drt_pkg::RP_CYC)) begin
          st_next    = ST_IDLE;
          rsp_v_next = data_op;
          if (kind_reg == drt_pkg::K_RD && hidden_ref_i && ref_ras_only_i) begin
            hid_next = 1'b1;
          end
        end
      end
      default: begin
        st_next  = ST_IDLE;
        pin_next = drt_pkg::PINS_IDLE;
      end
    endcase
    // Ready only when idle with no refresh owed
    ready_next = (st_next == ST_IDLE) && (pend_next == 2'h0) && !hid_next;
  end

  //----------------------------------------------------------
  // State registers
  //----------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_reg    <= ST_IDLE;
      kind_reg  <= drt_pkg::K_RD;
      ph_reg    <= '0;
      col_reg   <= 7'h00;
      pin_reg   <= drt_pkg::PINS_IDLE;
      ready_reg <= 1'b0;
      rsp_v_reg <= 1'b0;
      rdat_reg  <= 1'b0;
      tmr_reg   <= '0;
      pend_reg  <= 2'h0;
      hid_reg   <= 1'b0;
      row_reg   <= 7'h00;
    end else begin
      st_reg    <= st_next;
      kind_reg  <= kind_next;
      ph_reg    <= ph_next;
      col_reg   <= col_next;
      pin_reg   <= pin_next;
      ready_reg <= ready_next;
      rsp_v_reg <= rsp_v_next;
      rdat_reg  <= rdat_next;
      tmr_reg   <= tmr_next;
      pend_reg  <= pend_next;
      hid_reg   <= hid_next;
      row_reg   <= row_next;
    end
  end

  //----------------------------------------------------------
  // Data pin synchroniser
  //----------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      dq_s1_reg <= 1'b0;
      dq_s2_reg <= 1'b0;
    end else begin
      dq_s1_reg <= dout_i;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // Outputs straight from registers, no logic after the flops
  assign pins_o      = pin_reg;
  assign req_ready_o = ready_reg;
  assign rsp_valid_o = rsp_v_reg;
  assign rsp_rdata_o = rdat_reg;

  //----------------------------------------------------------
  // Assertions
  //----------------------------------------------------------
  a_rcl_lead: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(pin_reg.ras_n) && kind_reg != drt_pkg::K_CBR |-> pin_reg.cas_n)
    else $error("CAS not high as RAS falls");

  a_rcl_late: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(pin_reg.ras_n) && data_op |=> !pin_reg.cas_n)
    else $error("CAS late after RAS");

  a_rmw_row_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(pin_reg.cas_n) && kind_reg == drt_pkg::K_RMW |-> !pin_reg.ras_n [*5])
    else $error("RMW RAS hold short");

  a_rmw_col_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(pin_reg.ras_n) && kind_reg == drt_pkg::K_RMW |=> !pin_reg.cas_n [*5])
    else $error("RMW CAS hold short");

  a_rmw_we_pulse: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(pin_reg.we_n) && kind_reg == drt_pkg::K_RMW |->
      !pin_reg.cas_n && !pin_reg.ras_n ##1 !pin_reg.we_n && !pin_reg.cas_n
      ##1 pin_reg.we_n && pin_reg.cas_n)
    else $error("RMW write pulse wrong");

  a_din_stable: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $changed(pin_reg.din) |-> pin_reg.ras_n && pin_reg.cas_n)
    else $error("Data in moved inside cycle");

  a_we_read: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(pin_reg.cas_n) && kind_reg != drt_pkg::K_WR |-> pin_reg.we_n)
    else $error("WE low at CAS fall on read");

  a_ref_backlog: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    pend_reg <= 2'h1)
    else $error("Refresh falling behind");

  a_cbr_order: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(pin_reg.ras_n) && kind_reg == drt_pkg::K_CBR |->
      !pin_reg.cas_n && !$past(pin_reg.cas_n))
    else $error("CBR without CAS lead");

endmodule : drt_host

// ===== drt_dram_mdl.sv
// Behavioural 16K x 1 DRAM with latched output, driving the inverse of the latch when released
`timescale 1ns/1ps

module drt_dram_mdl #(
  parameter int REF_NS = 204800, // Refresh interval plus jitter, ns
  parameter int DHM_NS = 125     // RMW data hold, slowest grade
) (
  // Host pins
  input  wire drt_pkg::drt_pins_t pins_i,
  input  wire logic               age_en_i,
  // Device answer
  output logic                    dout_o,
  output int                      viol_o
);
  //------------------------------------------------------------
  // State
  //------------------------------------------------------------
  logic        mem [16384]; // Cell array
  logic        lat;         // Output latch
  logic        oe;          // Output driven
  logic        rmw;         // Write strobe fell inside cycle
  logic [6:0]  row;         // Latched row word
  logic [13:0] cel;         // Selected cell
  int          seq;         // Cancels stale read data
  realtime     t_ras;       // RAS fall time
  realtime     t_cas;       // CAS fall time
  realtime     t_we;        // Write strobe fall time
  realtime     last [128];  // Last refresh per row, 0 unknown

  // Released line shows the inverse of the latch
  assign dout_o = oe ? lat : ~lat;

  // Count and report a host fault
  task automatic flag(input string m);
    viol_o++;
    $display("Error %0t: %s", $time, m);
  endtask : flag

  // Refresh one row, checking its age
  task automatic rfsh(input logic [6:0] r);
    if (age_en_i && last[r] > 0 && $realtime - last[r] > REF_NS) flag("row refresh late");
    last[r] = $realtime;
  endtask : rfsh

  // Read data shows one column access time after CAS
  task automatic show(input int s, input logic d);
    #(drt_pkg::T_CAC_NS);
    if (s == seq) begin
      lat = d;
      oe  = 1'b1;
    end
  endtask : show

  //------------------------------------------------------------
  // Strobe edges
  //------------------------------------------------------------
  initial begin
    viol_o = 0;
    lat    = 1'b0;
    oe     = 1'b0;
    rmw    = 1'b0;
    seq    = 0;
    foreach (mem[i]) mem[i] = ^i;
    foreach (last[i]) last[i] = 0;
  end

  // Fresh age window
  always @(posedge age_en_i) foreach (last[i]) last[i] = 0;

  // Row strobe: latch row or run a CAS-first refresh
  always @(negedge pins_i.ras_n) begin
    t_ras = $realtime;
    rmw   = 1'b0;
    if (!pins_i.cas_n) begin // Internal refresh, two rows per cycle
      rfsh({1'b0, pins_i.mux_addr[5:0]});
      rfsh({1'b1, pins_i.mux_addr[5:0]});
    end else begin // Output latch left alone
      row = pins_i.mux_addr;
      rfsh(row);
    end
  end

  // Column strobe: float, then write or read
  always @(negedge pins_i.cas_n) begin
    seq++;
    t_cas = $realtime;
    oe    = 1'b0;
    if (!pins_i.ras_n) begin
      if (t_cas - t_ras < drt_pkg::T_RCL_NS) flag("CAS lead short");
      if (t_cas - t_ras > drt_pkg::T_RAC_NS - drt_pkg::T_CAC_NS) flag("CAS lead long");
      cel = {pins_i.mux_addr, row};
      if (!pins_i.we_n) begin // Early write, output follows input
        mem[cel] = pins_i.din;
        lat      = pins_i.din;
        oe       = 1'b1;
      end else begin // Read, also first half of RMW
        fork
          show(seq, mem[cel]);
        join_none
      end
    end
  end

  // Write strobe inside the cycle: modify phase
  always @(negedge pins_i.we_n) begin
    if (!pins_i.ras_n && !pins_i.cas_n) begin
      rmw      = 1'b1;
      t_we     = $realtime;
      mem[cel] = pins_i.din;
    end
  end

  // Host hold times in RMW
  always @(pins_i.din) if (rmw && $realtime - t_we < DHM_NS) flag("RMW data hold short");
  always @(posedge pins_i.we_n) if (rmw && $realtime - t_we < drt_pkg::T_WP_NS) flag("write pulse short");
  always @(posedge pins_i.cas_n) begin
    if (rmw && $realtime - t_ras < drt_pkg::T_CWH_NS) flag("RMW CAS hold short");
    if (rmw && $realtime - t_we < drt_pkg::T_CWL_NS) flag("write to CAS lead short");
  end
  always @(posedge pins_i.ras_n) if (rmw && $realtime - t_cas < drt_pkg::T_RWH_NS) flag("RMW RAS hold short");
endmodule : drt_dram_mdl

// ===== tb.sv
// Self-checking bench for the DRAM host controller
`timescale 1ns/1ps

module tb;
  //------------------------------------------------------------
  // Bench state
  //------------------------------------------------------------
  localparam int RCYC = 2048; // Short refresh interval, cycles

  typedef struct packed {
    drt_pkg::drt_op_t op;    // Operation
    logic [13:0]      addr;  // Cell address
    logic             wdata; // Write data
    logic             rdata; // Expected read data
  } drt_row_t;

  logic               clk;       // Core clock
  logic               rst;       // Synchronous reset
  logic               req_valid; // Request present
  drt_pkg::drt_req_t  req;       // Request word
  logic               req_ready; // Request taken
  logic               rsp_valid; // Answer pulse
  logic               rsp_rdata; // Answer data
  logic               ror;       // RAS-only refresh mode
  logic               hid;       // Hidden refresh
  drt_pkg::drt_pins_t pins;      // DRAM pins
  logic               dout;      // Data line
  logic               age_en;    // Refresh age check on
  int                 viol;      // Model faults
  int                 errors;    // Mismatches
  int                 checks;    // Comparisons
  int                 n_ror;     // RAS-only refreshes
  int                 n_cbr;     // CAS-first refreshes
  drt_row_t           tbl [10] = '{
    '{drt_pkg::OP_WRITE, 14'h0001, 1'b1, 1'b0}, '{drt_pkg::OP_WRITE, 14'h0080, 1'b0, 1'b0},
    '{drt_pkg::OP_READ, 14'h0001, 1'b0, 1'b1}, '{drt_pkg::OP_READ, 14'h0080, 1'b0, 1'b0},
    '{drt_pkg::OP_RMW, 14'h0001, 1'b0, 1'b1}, '{drt_pkg::OP_READ, 14'h0001, 1'b0, 1'b0},
    '{drt_pkg::OP_READ, 14'h3fff, 1'b0, 1'b0}, '{drt_pkg::OP_RMW, 14'h3fff, 1'b1, 1'b0},
    '{drt_pkg::OP_RMW, 14'h3fff, 1'b0, 1'b1}, '{drt_pkg::OP_READ, 14'h2aaa, 1'b0, 1'b1}};

  drt_host #(.REF_CYC(RCYC)) drt_host_i (
    .core_clk_i     (clk),
    .sys_rst_i      (rst),
    .req_valid_i    (req_valid),
    .req_i          (req),
    .req_ready_o    (req_ready),
    .rsp_valid_o    (rsp_valid),
    .rsp_rdata_o    (rsp_rdata),
    .ref_ras_only_i (ror),
    .hidden_ref_i   (hid),
    .pins_o         (pins),
    .dout_i         (dout)
  );

  // Jitter allowance of 32 cycles, one CAS-first spacing, on the age check
  drt_dram_mdl #(.REF_NS((RCYC + 32) * 100)) drt_dram_mdl_i (
    .pins_i   (pins),
    .age_en_i (age_en),
    .dout_o   (dout),
    .viol_o   (viol)
  );

  //------------------------------------------------------------
  // Helpers
  //------------------------------------------------------------
  always #50 clk = ~clk;

  // Count refresh kinds by CAS level at RAS fall
  always @(negedge pins.ras_n) if (pins.cas_n) n_ror++; else n_cbr++;

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : cmp

  // One request, answer delay and data checked
  task automatic access(input drt_row_t r);
    int n;
    int hr;
    n = 0;
    req_valid <= 1'b1;
    req       <= '{op: r.op, addr: r.addr, wdata: r.wdata};
    @(posedge clk);
    while (req_ready !== 1'b1) @(posedge clk);
    req_valid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 20);
    cmp(n, (r.op == drt_pkg::OP_RMW) ? 9 : 7, "answer delay");
    if (r.op != drt_pkg::OP_WRITE) cmp({31'h0, rsp_rdata}, {31'h0, r.rdata}, "read data");
    // Exactly one RAS-only cycle must start right after the answer
    hr = n_ror;
    if (hid && r.op == drt_pkg::OP_READ) begin
      repeat (3) @(posedge clk);
      cmp(n_ror - hr, 1, "hidden refresh");
    end
  endtask : access

  // Table, then refresh counts over one interval
  task automatic run_pass(input logic m_ror, input logic m_hid);
    int hr;
    int hc;
    ror    <= m_ror;
    hid    <= m_hid;
    age_en <= 1'b0;
    repeat (300) @(posedge clk);
    age_en <= 1'b1;
    foreach (tbl[i]) access(tbl[i]);
    repeat (200) @(posedge clk);
    hr = n_ror;
    hc = n_cbr;
    repeat (RCYC) @(posedge clk);
    cmp(n_ror - hr, m_ror ? 128 : 0, "RAS-only count");
    cmp(n_cbr - hc, m_ror ? 0 : 64, "CAS-first count");
    repeat (RCYC + 300) @(posedge clk);
  endtask : run_pass

  task automatic finish_test;
    if (errors + viol == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    $display("Error %0t: run hung", $time);
    finish_test();
  end

  //------------------------------------------------------------
  // Main sequence
  //------------------------------------------------------------
  initial begin
    clk       = 1'b0;
    rst       = 1'b1;
    req_valid = 1'b0;
    req       = '0;
    ror       = 1'b1;
    hid       = 1'b0;
    age_en    = 1'b0;
    errors    = 0;
    checks    = 0;
    n_ror     = 0;
    n_cbr     = 0;
    repeat (16) @(posedge clk);
    cmp({21'h0, pins}, {21'h0, drt_pkg::PINS_IDLE}, "pins in reset");
    cmp({30'h0, req_ready, rsp_valid}, 0, "handshake in reset");
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    cmp({31'h0, req_ready}, 1, "ready after reset");
    run_pass(1'b1, 1'b0);
    run_pass(1'b0, 1'b0);
    run_pass(1'b1, 1'b1);
    // Reset in the middle of a read
    age_en    <= 1'b0;
    req_valid <= 1'b1;
    req       <= '{op: drt_pkg::OP_READ, addr: 14'h0001, wdata: 1'b0};
    @(posedge clk);
    while (req_ready !== 1'b1) @(posedge clk);
    req_valid <= 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    cmp({21'h0, pins}, {21'h0, drt_pkg::PINS_IDLE}, "pins after cut");
    cmp({30'h0, req_ready, rsp_valid}, 0, "handshake after cut");
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    cmp({31'h0, req_ready}, 1, "ready after cut");
    finish_test();
  end
endmodule : tb
